//--- src/i2cse_consts.svh
// constants of the two-wire slave engine: address patterns, counts, resets
// assumes inclusion by bare name from the engine
`ifndef I2CSE_CONSTS_SVH
`define I2CSE_CONSTS_SVH

`define I2CSE_HDR10_HI   5'h1e  // high pattern of a 10-bit first byte
`define I2CSE_GC_ADDR    8'h00  // general call byte, direction 0
`define I2CSE_ADDR_BITS  4'h8   // bits shifted before the ninth clock
`define I2CSE_TX_LAST    4'h7   // fall count before the last data bit ends
`define I2CSE_REL_RST    1'b1   // clock release bit after reset
`define I2CSE_SYNC_DEPTH 4      // toggle stages into the core clock

`endif

//--- src/i2cse_pkg.sv
// types shared by the two-wire slave engine
// assumes the constants header sits on the include path
package i2cse_pkg;

    // engine states, one-hot
    typedef enum logic [6:0] {
        I2CSE_IDLE  = 7'h01,  // waiting for a start
        I2CSE_ADDR  = 7'h02,  // shifting an address byte
        I2CSE_ACKA  = 7'h04,  // acknowledging an address
        I2CSE_RX    = 7'h08,  // shifting a data byte in
        I2CSE_ACKR  = 7'h10,  // answering a received byte
        I2CSE_TX    = 7'h20,  // shifting a data byte out
        I2CSE_TXACK = 7'h40   // listening for the master answer
    } i2cse_state_e;

    // configuration bits from software
    typedef struct packed {
        logic       module_enable;
        logic       addr10_mode;
        logic       stretch_enable;
        logic       accept_all_enable;
        logic       general_call_enable;
        logic [9:0] own_address;
    } i2cse_cfg_s;

    // status bits shown to software
    typedef struct packed {
        logic rx_full;
        logic rx_overflow;
        logic tx_full;
        logic scl_release;
        logic addr10_matched;
        logic gc_received;
    } i2cse_stat_s;

endpackage

//--- src/i2cse_slave.sv
// slave engine of a two-wire serial controller: address match, receive,
// transmit, clock stretching and event pulses
// assumes open-drain pins resolved outside; link_clk free-runs and
// oversamples the pins; software bits arrive as plain ports on clock
//
// What this block does
// - idle until start, then shift eight bits
// - 7-bit compare: own 6:0 versus shift 7:1
// - sample each data bit at clock rise
// - address match acks, flags slave, buffer untouched
// - read direction: ack, stretch if transmit register empty, software releases
// - transmit changes data on falls; pulse ninth
// - write direction: load buffer, then acknowledge
// - full buffer: no ack, no load, pulse
// - overflow with empty buffer: load, no ack
// - 10-bit first byte: header plus high bits
// - 10-bit second byte: low eight bits compare
// - acked transmit with empty register stretches
// - transmit stretching ignores stretch enable
// - software may always set clock release
// - receive stretching when full, stretch enabled
// - software clear waits for a clock fall
// - stretch disabled: software release clears ignored
// - two event flags: master and slave
// - accept-all takes every address
// - general call compare when enabled
// - general call loads buffer, flags master
// - after repeated start, first byte suffices
// - addressing mode bit picks 7 or 10
`timescale 1ns/1ns
`default_nettype none
`include "i2cse_consts.svh"

module i2cse_slave (
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               link_clk,
    input  wire logic               scl_i,
    output logic                    scl_o,
    output logic                    scl_oe,
    input  wire logic               sda_i,
    output logic                    sda_o,
    output logic                    sda_oe,
    input  wire i2cse_pkg::i2cse_cfg_s cfg,
    input  wire logic               tx_write,
    input  wire logic [7:0]         tx_wdata,
    input  wire logic               rx_read,
    input  wire logic               overflow_clear,
    input  wire logic               scl_release_set,
    input  wire logic               scl_release_clear,
    input  wire logic               master_msg_done,
    output logic [7:0]              rx_buffer,
    output i2cse_pkg::i2cse_stat_s  stat,
    output logic                    slave_event_flag,
    output logic                    master_event_flag
);
    import i2cse_pkg::*;

    // ---------------- link domain ----------------
    logic [1:0] lrst_q;      // reset carried into the link domain
    logic       link_rst_n;  // link-side reset, active low
    logic [1:0] scl_sync_q;  // pin synchroniser
    logic [1:0] sda_sync_q;  // pin synchroniser
    logic       scl_prev_q;  // last settled clock level
    logic       sda_prev_q;  // last settled data level
    logic [3:0] tg_q;        // toggles: stop, start, fall, rise
    logic       sda_smp_q;   // data bit caught at the last rise

    // reset release is seen a few link edges after the core sees it
    always_ff @(posedge link_clk) begin
        lrst_q <= {lrst_q[0], rst_n};
    end
    assign link_rst_n = lrst_q[1];

    // pins pass two flops before any detector reads them
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            scl_sync_q <= 2'h3;
            sda_sync_q <= 2'h3;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[0], scl_i};
            sda_sync_q <= {sda_sync_q[0], sda_i};
            scl_prev_q <= scl_sync_q[1];
            sda_prev_q <= sda_sync_q[1];
        end
    end

    // bus events become toggles so the core clock can catch each one
    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            tg_q      <= 4'h0;
            sda_smp_q <= 1'b1;
        end else begin
            // stop: data rises while clock high
            tg_q[3] <= tg_q[3] ^ (scl_sync_q[1] & scl_prev_q
                                  & sda_sync_q[1] & ~sda_prev_q);
            // start: data falls while clock high
            tg_q[2] <= tg_q[2] ^ (scl_sync_q[1] & scl_prev_q
                                  & ~sda_sync_q[1] & sda_prev_q);
            tg_q[1] <= tg_q[1] ^ (~scl_sync_q[1] & scl_prev_q);
            tg_q[0] <= tg_q[0] ^ (scl_sync_q[1] & ~scl_prev_q);
            if (scl_sync_q[1] && !scl_prev_q) begin
                sda_smp_q <= sda_sync_q[1];
            end
        end
    end

    // ---------------- crossing into clock ----------------
    logic [3:0] tg_s1_q, tg_s2_q, tg_s3_q, tg_s4_q;  // toggle stages
    logic [1:0] sda_x_q;                             // data bit stages
    logic       ev_stop, ev_start, ev_fall, ev_rise; // one-cycle events
    logic       sda_bit;                             // settled sample

    // the event is taken a stage late so the data bit has settled
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tg_s1_q <= 4'h0;
            tg_s2_q <= 4'h0;
            tg_s3_q <= 4'h0;
            tg_s4_q <= 4'h0;
            sda_x_q <= 2'h3;
        end else begin
            tg_s1_q <= tg_q;
            tg_s2_q <= tg_s1_q;
            tg_s3_q <= tg_s2_q;
            tg_s4_q <= tg_s3_q;
            sda_x_q <= {sda_x_q[0], sda_smp_q};
        end
    end
    assign {ev_stop, ev_start, ev_fall, ev_rise} = tg_s3_q ^ tg_s4_q;
    assign sda_bit = sda_x_q[1];

    // ---------------- core state ----------------
    i2cse_state_e state_q;    // engine state
    logic [3:0]   cnt_q;      // bit counter within a byte
    logic [7:0]   rx_shift_reg;
    logic [7:0]   tx_shift_q; // outgoing byte, msb on the wire
    logic [7:0]   tx_register;
    logic         ack_q;      // drive ack during the ninth bit
    logic         rd_q;       // address asked for a read
    logic         part_q;     // 10-bit header accepted, low byte next
    logic         gc_q;       // address was the general call
    logic         lo_phase_q; // expecting the 10-bit low byte
    logic         loaded_q;   // transmit shifter holds a byte
    logic         mack_q;     // master acked the last byte
    logic         rx_full_q, rx_overflow_q, tx_full_q;
    logic         scl_release_q, addr10_matched_q, clr_pend_q;
    logic         sda_oe_q, scl_oe_q, sev_q, mev_q;

    // address decode, valid once eight bits are in
    logic rw, m7, hi10, lo10, gc_hit;
    logic a_ack, a_read, a_part, a_gc;
    logic run, byte_end, rx_ack_ok;
    logic tx_load, rx_load, ovf_set, hw_clr;

    assign rw     = rx_shift_reg[0];
    assign m7     = rx_shift_reg[7:1] == cfg.own_address[6:0];
    assign hi10   = rx_shift_reg[7:3] == `I2CSE_HDR10_HI
                 && rx_shift_reg[2:1] == cfg.own_address[9:8];
    assign lo10   = rx_shift_reg == cfg.own_address[7:0];
    assign gc_hit = cfg.general_call_enable
                 && rx_shift_reg == `I2CSE_GC_ADDR;

    // which kind of address acceptance applies
    always_comb begin
        a_ack  = 1'b0;
        a_read = 1'b0;
        a_part = 1'b0;
        a_gc   = 1'b0;
        if (cfg.accept_all_enable) begin
            a_ack  = 1'b1;
            a_read = rw;
        end else if (gc_hit) begin
            a_ack = 1'b1;
            a_gc  = 1'b1;
        end else if (!cfg.addr10_mode) begin
            a_ack  = m7;
            a_read = m7 & rw;
        end else if (lo_phase_q) begin
            a_ack = lo10;
        end else if (hi10 && !rw) begin
            a_ack  = 1'b1;
            a_part = 1'b1;
        end else if (hi10 && addr10_matched_q) begin
            a_ack  = 1'b1;
            a_read = 1'b1;
        end
    end

    assign run       = cfg.module_enable & ~ev_stop & ~ev_start;
    assign byte_end  = run & ev_fall & (cnt_q == `I2CSE_ADDR_BITS);
    assign rx_ack_ok = ~rx_full_q & ~rx_overflow_q;
    assign tx_load   = run & (state_q == I2CSE_TX) & ~loaded_q & tx_full_q;
    assign rx_load   = byte_end & ~rx_full_q
                     & ((state_q == I2CSE_RX)
                        | ((state_q == I2CSE_ADDR) & a_gc));
    assign ovf_set   = byte_end & (state_q == I2CSE_RX) & rx_full_q;

    // protocol sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_q      <= I2CSE_IDLE;
            cnt_q        <= 4'h0;
            rx_shift_reg <= 8'h00;
            tx_shift_q   <= 8'hff;
            ack_q        <= 1'b0;
            rd_q         <= 1'b0;
            part_q       <= 1'b0;
            gc_q         <= 1'b0;
            lo_phase_q   <= 1'b0;
            loaded_q     <= 1'b0;
            mack_q       <= 1'b0;
        end else if (!cfg.module_enable || ev_stop) begin
            state_q    <= I2CSE_IDLE;
            ack_q      <= 1'b0;
            loaded_q   <= 1'b0;
            lo_phase_q <= 1'b0;
        end else if (ev_start) begin
            // plain and repeated start both restart addressing
            state_q    <= I2CSE_ADDR;
            cnt_q      <= 4'h0;
            ack_q      <= 1'b0;
            loaded_q   <= 1'b0;
            lo_phase_q <= 1'b0;
        end else begin
            case (state_q)
                I2CSE_ADDR, I2CSE_RX: begin
                    if (ev_rise && cnt_q != `I2CSE_ADDR_BITS) begin
                        rx_shift_reg <= {rx_shift_reg[6:0], sda_bit};
                        cnt_q        <= cnt_q + 4'h1;
                    end else if (byte_end) begin
                        if (state_q == I2CSE_RX) begin
                            state_q <= I2CSE_ACKR;
                            ack_q   <= rx_ack_ok;
                        end else if (a_ack) begin
                            state_q <= I2CSE_ACKA;
                            ack_q   <= 1'b1;
                            rd_q    <= a_read;
                            part_q  <= a_part;
                            gc_q    <= a_gc;
                        end else begin
                            state_q <= I2CSE_IDLE;
                        end
                    end
                end
                I2CSE_ACKA: begin
                    if (ev_fall) begin
                        ack_q      <= 1'b0;
                        cnt_q      <= 4'h0;
                        lo_phase_q <= part_q;
                        if (rd_q) begin
                            state_q <= I2CSE_TX;
                        end else if (part_q) begin
                            state_q <= I2CSE_ADDR;
                        end else begin
                            state_q <= I2CSE_RX;
                        end
                    end
                end
                I2CSE_ACKR: begin
                    if (ev_fall) begin
                        ack_q   <= 1'b0;
                        cnt_q   <= 4'h0;
                        state_q <= I2CSE_RX;
                    end
                end
                I2CSE_TX: begin
                    if (tx_load) begin
                        tx_shift_q <= tx_register;
                        loaded_q   <= 1'b1;
                    end else if (ev_fall && loaded_q) begin
                        // next bit goes out right after the fall
                        tx_shift_q <= {tx_shift_q[6:0], 1'b1};
                        cnt_q      <= cnt_q + 4'h1;
                        if (cnt_q == `I2CSE_TX_LAST) begin
                            state_q  <= I2CSE_TXACK;
                            loaded_q <= 1'b0;
                        end
                    end
                end
                I2CSE_TXACK: begin
                    if (ev_rise) begin
                        mack_q <= ~sda_bit;
                    end else if (ev_fall) begin
                        cnt_q   <= 4'h0;
                        // a missing ack ends the read; wait for stop
                        state_q <= mack_q ? I2CSE_TX : I2CSE_IDLE;
                    end
                end
                I2CSE_IDLE: begin
                    cnt_q <= 4'h0;
                end
                default: begin
                    state_q <= I2CSE_IDLE;
                end
            endcase
        end
    end

    // receive buffer and its flags; hardware set wins over software clear
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_buffer     <= 8'h00;
            rx_full_q     <= 1'b0;
            rx_overflow_q <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_buffer <= rx_shift_reg;
            end
            rx_full_q     <= rx_load | (rx_full_q & ~rx_read);
            rx_overflow_q <= ovf_set | (rx_overflow_q & ~overflow_clear);
        end
    end

    // transmit register; a write landing with the load keeps it full
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_register <= 8'h00;
            tx_full_q   <= 1'b0;
        end else begin
            if (tx_write) begin
                tx_register <= tx_wdata;
            end
            tx_full_q <= tx_write | (tx_full_q & ~tx_load);
        end
    end

    // 10-bit match status; a stop forgets the prior match
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            addr10_matched_q <= 1'b0;
        end else if (ev_stop || !cfg.module_enable) begin
            addr10_matched_q <= 1'b0;
        end else if (byte_end && state_q == I2CSE_ADDR
                     && cfg.addr10_mode && !cfg.accept_all_enable) begin
            if (lo_phase_q) begin
                addr10_matched_q <= lo10;
            end else if (!(hi10 && rw)) begin
                addr10_matched_q <= 1'b0;
            end
        end
    end

    // stretch requests: automatic at the ninth falling edge, pending software clears at the next fall
    always_comb begin
        hw_clr = 1'b0;
        if (run && ev_fall) begin
            if (state_q == I2CSE_ACKA && rd_q && !tx_full_q) begin
                hw_clr = 1'b1;
            end
            if (state_q == I2CSE_TXACK && mack_q && !tx_full_q) begin
                hw_clr = 1'b1;
            end
            if (state_q == I2CSE_ACKR && cfg.stretch_enable && rx_full_q) begin
                hw_clr = 1'b1;
            end
            if (clr_pend_q) begin
                hw_clr = 1'b1;
            end
        end
    end

    // clock release bit; a software set always wins
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            scl_release_q <= `I2CSE_REL_RST;
            clr_pend_q    <= 1'b0;
        end else begin
            scl_release_q <= scl_release_set
                           | (scl_release_q & ~hw_clr);
            // a clear only waits; it bites on the next falling edge
            if (scl_release_set || (run && ev_fall)) begin
                clr_pend_q <= 1'b0;
            end else if (scl_release_clear && cfg.stretch_enable) begin
                clr_pend_q <= 1'b1;
            end
        end
    end

    // pin drive and event pulses, all from flops
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
            sev_q    <= 1'b0;
            mev_q    <= 1'b0;
        end else begin
            sda_oe_q <= cfg.module_enable
                      & ((((state_q == I2CSE_ACKA) | (state_q == I2CSE_ACKR))
                          & ack_q)
                         | ((state_q == I2CSE_TX) & loaded_q
                            & ~tx_shift_q[7]));
            scl_oe_q <= cfg.module_enable & ~scl_release_q;
            sev_q    <= run & ev_fall
                      & (((state_q == I2CSE_ACKA) & ~gc_q)
                         | (state_q == I2CSE_ACKR)
                         | (state_q == I2CSE_TXACK));
            mev_q    <= master_msg_done
                      | (run & ev_fall & (state_q == I2CSE_ACKA) & gc_q);
        end
    end

    assign sda_o                = 1'b0;
    assign scl_o                = 1'b0;
    assign sda_oe               = sda_oe_q;
    assign scl_oe               = scl_oe_q;
    assign slave_event_flag     = sev_q;
    assign master_event_flag    = mev_q;
    assign stat.rx_full         = rx_full_q;
    assign stat.rx_overflow     = rx_overflow_q;
    assign stat.tx_full         = tx_full_q;
    assign stat.scl_release     = scl_release_q;
    assign stat.addr10_matched  = addr10_matched_q;
    assign stat.gc_received     = gc_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence addr_done_s;
        state_q == I2CSE_ADDR && byte_end;
    endsequence
    sequence ninth_fall_s;
        run && ev_fall && state_q == I2CSE_ACKA;
    endsequence

    idle_when_off_a: assert property (
        !cfg.module_enable |=> state_q == I2CSE_IDLE)
        else $error("engine not idle while disabled");
    addr7_ack_a: assert property (
        addr_done_s and !cfg.addr10_mode && !cfg.accept_all_enable && m7
        |=> ack_q ##1 sda_oe)
        else $error("7-bit match not acknowledged");
    rise_sample_a: assert property (
        run && ev_rise && state_q == I2CSE_ADDR && cnt_q < 4'h8
        |=> rx_shift_reg[0] == $past(sda_bit))
        else $error("bit not taken at clock rise");
    match_flag_a: assert property (
        ninth_fall_s and !gc_q |=> slave_event_flag ##1 !slave_event_flag)
        else $error("slave flag not one pulse at ninth fall");
    full_nack_a: assert property (
        byte_end && state_q == I2CSE_RX && rx_full_q
        |=> !ack_q && $stable(rx_buffer) && rx_overflow_q)
        else $error("full buffer byte mishandled");
    ovf_load_a: assert property (
        byte_end && state_q == I2CSE_RX && !rx_full_q && rx_overflow_q
        |=> !ack_q && rx_full_q && rx_buffer == $past(rx_shift_reg))
        else $error("overflow load or nack wrong");
    tx_stretch_a: assert property (
        run && ev_fall && state_q == I2CSE_TXACK && mack_q && !tx_full_q
        && !scl_release_set |=> !scl_release_q ##1 scl_oe)
        else $error("transmit stretch missing");
    sw_clr_ignored_a: assert property (
        !cfg.stretch_enable && scl_release_q && !hw_clr
        |=> scl_release_q)
        else $error("release changed with stretching off");
    set_wins_a: assert property (
        scl_release_set |=> scl_release_q)
        else $error("software set of release lost");
    stop_idle_a: assert property (
        ev_stop |=> state_q == I2CSE_IDLE && !sda_oe_q)
        else $error("stop did not return to idle");
    gc_master_a: assert property (
        ninth_fall_s and gc_q |=> master_event_flag && !slave_event_flag)
        else $error("general call did not flag master");

endmodule

`default_nettype wire

//--- verif/i2cse_master.sv
// bus master model driving both wires of the two-wire slave
// assumes pull-ups; the bench resolves wire levels from all drivers
`timescale 1ns/1ns
`default_nettype none
module i2cse_master (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    // both wires released at power-up
    initial {scl_low, sda_low} = 2'b00;
    // start or repeated start: data falls while clock is high
    task automatic start;
        sda_low = 1'b0;
        #150 scl_low = 1'b0;
        #150 sda_low = 1'b1;
        #150 scl_low = 1'b1;
    endtask
    // stop: data rises while clock is high
    task automatic stop;
        sda_low = 1'b1;
        #150 scl_low = 1'b0;
        #150 sda_low = 1'b0;
    endtask
    // one bit; a stretched clock is waited out, but not forever
    task automatic xbit(input logic b, output logic r);
        sda_low = ~b;
        #150 scl_low = 1'b0;
        for (int n = 0; n < 20000 && scl !== 1'b1; n++) #10;
        #150 r = sda;
        scl_low = 1'b1;
    endtask
    // byte msb first, then the answer bit; leaves time for event pulses
    task automatic xbyte(input logic [7:0] d, input logic ak,
                         output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(ak, a);
        sda_low = 1'b0;
        #250;
    endtask
endmodule
`default_nettype wire

//--- verif/i2cse_slave_tb.sv
// self-checking bench of the two-wire slave engine
// assumes the master model on the wires and pull-ups on both
`timescale 1ns/1ns
`default_nettype none
module i2cse_slave_tb;
    import i2cse_pkg::*;
    logic        clock = 1'b0, link_clk = 1'b0, rst_n = 1'b0;
    logic        tw = 1'b0, rr = 1'b0, rs = 1'b0, md = 1'b0;
    logic        a, sev, mev, scl_oe, sda_oe, m_scl, m_sda;
    logic [7:0]  q, rx_buffer;
    i2cse_cfg_s  cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 10'h02a};
    i2cse_stat_s stat;
    int          err_total = 0, check_count = 0, ev = 0, mv = 0;
    wire         scl = ~(scl_oe | m_scl);  // pull-up wired-and
    wire         sda = ~(sda_oe | m_sda);
    initial forever #2 clock = ~clock;
    initial forever #15 link_clk = ~link_clk;
    // event pulses counted; they last one cycle only
    always @(posedge clock) begin
        if (sev === 1'b1) ev++;
        if (mev === 1'b1) mv++;
    end
    i2cse_slave dut (.clock, .rst_n, .link_clk, .scl_i(scl), .scl_o(),
        .scl_oe, .sda_i(sda), .sda_o(), .sda_oe, .cfg, .tx_write(tw),
        .tx_wdata(8'ha7), .rx_read(rr), .overflow_clear(1'b0),
        .scl_release_set(rs), .scl_release_clear(1'b0),
        .master_msg_done(md), .rx_buffer, .stat,
        .slave_event_flag(sev), .master_event_flag(mev));
    i2cse_master m (.scl, .sda, .scl_low(m_scl), .sda_low(m_sda));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    // one-cycle software pulse on {tx_write, rx_read, release set, done}
    task automatic sw(input logic [3:0] k);
        @(negedge clock) {tw, rr, rs, md} = k;
        @(negedge clock) {tw, rr, rs, md} = 4'h0;
    endtask
    task automatic give_verdict;
        $display("mismatches %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // write two bytes; the second finds the buffer still full
    task automatic s_write;
        m.start;
        m.xbyte(8'h54, 1'b1, q, a);
        chk({7'h0, a}, 8'h00);
        chk(ev[7:0], 8'h01);
        m.xbyte(8'h5c, 1'b1, q, a);
        chk({7'h0, a}, 8'h00);
        chk(rx_buffer, 8'h5c);
        m.xbyte(8'h33, 1'b1, q, a);
        chk({a, rx_buffer[6:0]}, 8'hdc);
        chk(ev[7:0], 8'h03);
        m.stop;
        m.start;
        m.xbyte(8'h2a, 1'b1, q, a);
        chk({7'h0, a}, 8'h01);
        m.stop;
    endtask
    // 10-bit write address, then a reread through a repeated start
    task automatic s_ten;
        @(negedge clock) cfg.addr10_mode = 1'b1;
        m.start;
        m.xbyte(8'hf0, 1'b1, q, a);
        chk({7'h0, a}, 8'h00);
        m.xbyte(8'h2a, 1'b1, q, a);
        chk({6'h0, a, stat.addr10_matched}, 8'h01);
        m.start;
        m.xbyte(8'hf1, 1'b1, q, a);
        chk({7'h0, a}, 8'h00);
        fork
            m.xbyte(8'hff, 1'b1, q, a);
            begin
                repeat (200) @(negedge clock);
                chk({6'h0, stat.scl_release, scl}, 8'h00);
                sw(4'h8);
                sw(4'h2);
            end
        join
        chk(q, 8'ha7);
        m.stop;
        @(negedge clock) cfg.addr10_mode = 1'b0;
    endtask
    // read with an empty transmit register: clock held until released
    task automatic s_read;
        m.start;
        m.xbyte(8'h55, 1'b1, q, a);
        chk({7'h0, a}, 8'h00);
        fork
            m.xbyte(8'hff, 1'b1, q, a);
            begin
                repeat (200) @(negedge clock);
                chk({6'h0, stat.scl_release, scl}, 8'h00);
                sw(4'h8);
                sw(4'h2);
            end
        join
        chk(q, 8'ha7);
        chk(ev[7:0], 8'h05);
        m.stop;
    endtask
    // general call lands in the buffer and raises the master flag
    task automatic s_gc;
        @(negedge clock) cfg.general_call_enable = 1'b1;
        sw(4'h4);
        sw(4'h1);
        m.start;
        m.xbyte(8'h00, 1'b1, q, a);
        chk({7'h0, a}, 8'h00);
        chk(rx_buffer, 8'h00);
        chk(mv[7:0], 8'h02);
        m.stop;
    endtask
    initial begin
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (20) @(negedge clock);
        chk({7'h0, stat.scl_release}, 8'h01);
        s_write;
        s_read;
        s_gc;
        s_ten;
        // a disabled engine lets go of both wires
        @(negedge clock) cfg.module_enable = 1'b0;
        repeat (3) @(negedge clock);
        chk({6'h0, scl_oe, sda_oe}, 8'h00);
        @(negedge clock) cfg.module_enable = 1'b1;
        give_verdict;
    end
    // hang guard, well beyond the few bytes of traffic
    initial begin
        #300000;
        err_total++;
        give_verdict;
    end
endmodule
`default_nettype wire
